// ### hw/tps_pkg.sv
// Constants for the triple rail power sequencer.
// Assumes a single 20 MHz clock and comparator flags arriving from the analogue side.
package tps_pkg;
   localparam int unsigned CLK_HZ          = 20000000;
   localparam int unsigned PHASE_TIME_US   = 1000;
   localparam int unsigned PUMP_RAMP_US    = 4000;
   localparam int unsigned PHASE_CYCLES    = (CLK_HZ / 1000000) * PHASE_TIME_US;
   localparam int unsigned RAMP_CYCLES     = (CLK_HZ / 1000000) * PUMP_RAMP_US;
   localparam int unsigned OSC_DIV         = 20;
   localparam int unsigned RAMP_W          = 8;
   localparam logic [1:0]  CEIL_QUARTER    = 2'h0;
   localparam logic [1:0]  CEIL_HALF       = 2'h1;
   localparam logic [1:0]  CEIL_3QUARTER   = 2'h2;
   localparam logic [1:0]  CEIL_FULL       = 2'h3;
   typedef enum logic [2:0] {
      TPS_OFF, TPS_REF, TPS_MAIN, TPS_NEG, TPS_POS, TPS_READY
   } tps_state_t;
endpackage

// ### hw/tps_flags_if.sv
// Carries the synchronised comparator flags between the synchroniser and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tps_flags_if;
   logic ref_ok;
   logic main_ok;
   logic neg_ok;
   logic pos_ok;
   logic ref_flt;
   logic main_flt;
   logic neg_flt;
   logic pos_flt;
   modport src (output ref_ok, main_ok, neg_ok, pos_ok, ref_flt, main_flt, neg_flt, pos_flt);
   modport dst (input ref_ok, main_ok, neg_ok, pos_ok, ref_flt, main_flt, neg_flt, pos_flt);
endinterface

// ### hw/tps_sync.sv
// Two flip-flop synchroniser for the eight comparator flags.
// Assumes flags are asynchronous levels from analogue comparators.
`timescale 1ns/100ps
module tps_sync
   import tps_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [7:0] flags_in,
   tps_flags_if.src        flags
);
   logic [7:0] meta_q;
   logic [7:0] sync_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q <= 8'h00;
         sync_q <= 8'h00;
      end else begin
         meta_q <= flags_in;
         sync_q <= meta_q;
      end
   end

   assign flags.ref_ok   = sync_q[0];
   assign flags.main_ok  = sync_q[1];
   assign flags.neg_ok   = sync_q[2];
   assign flags.pos_ok   = sync_q[3];
   assign flags.ref_flt  = sync_q[4];
   assign flags.main_flt = sync_q[5];
   assign flags.neg_flt  = sync_q[6];
   assign flags.pos_flt  = sync_q[7];
endmodule

// ### hw/tps_seq.sv
// Power-up sequencer: soft-start phases, rail enables, fault handling and ready pin.
// Assumes comparator flags from the analogue front end and a 20 MHz oscillator clock.
`timescale 1ns/100ps
module tps_seq
   import tps_pkg::*;
#(
   parameter int unsigned PHASE_CYC = PHASE_CYCLES,
   parameter int unsigned RAMP_CYC  = RAMP_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       converter_off_n,
   input  wire logic       ref_good,
   input  wire logic       main_feedback,
   input  wire logic       neg_pump_feedback,
   input  wire logic       pos_pump_feedback,
   input  wire logic       ref_fault,
   input  wire logic       main_fault,
   input  wire logic       neg_fault,
   input  wire logic       pos_fault,
   output logic            ref_enable,
   output logic            ref_discharge,
   output logic            main_enable,
   output logic [1:0]      switch_current_ceiling,
   output logic            neg_pump_enable,
   output logic            pos_pump_enable,
   output logic            pump_clock,
   output logic [RAMP_W-1:0] neg_ramp_level,
   output logic [RAMP_W-1:0] pos_ramp_level,
   output logic            ready_n_out,
   output logic            ready_n_oe_n,
   output logic            fault_seen
);
   ////////////////////////////////////////////////////////////////////////////
   tps_flags_if fl ();
   logic [1:0] off_meta_q;
   logic       off_n_q;
   logic       halt;

   tps_sync u_sync (
      .clock    (clock),
      .rst      (rst),
      .flags_in ({pos_fault, neg_fault, main_fault, ref_fault,
                  pos_pump_feedback, neg_pump_feedback, main_feedback, ref_good}),
      .flags    (fl)
   );

   // The shutdown pin is asynchronous, so it is synchronised before it steers anything.
   always_ff @(posedge clock) begin
      if (rst) begin
         off_meta_q <= 2'h0;
      end else begin
         off_meta_q <= {off_meta_q[0], converter_off_n};
      end
   end
   assign off_n_q = off_meta_q[1];
   assign halt    = rst | ~off_n_q;

   ////////////////////////////////////////////////////////////////////////////
   tps_state_t state_q;
   tps_state_t state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         TPS_OFF: begin
            state_d = TPS_REF;
         end
         TPS_REF: begin
            if (fl.ref_ok) begin
               state_d = TPS_MAIN;
            end
         end
         TPS_MAIN: begin
            if (fl.ref_flt) begin
               state_d = TPS_REF;
            end else if (fl.main_ok) begin
               state_d = TPS_NEG;
            end
         end
         TPS_NEG: begin
            if (fl.ref_flt) begin
               state_d = TPS_REF;
            end else if (fl.main_flt) begin
               state_d = TPS_MAIN;
            end else if (fl.neg_ok) begin
               state_d = TPS_POS;
            end
         end
         TPS_POS, TPS_READY: begin
            if (fl.ref_flt) begin
               state_d = TPS_REF;
            end else if (fl.main_flt) begin
               state_d = TPS_MAIN;
            end else if (fl.neg_flt) begin
               state_d = TPS_NEG;
            end else if (fl.pos_flt && state_q == TPS_READY) begin
               state_d = TPS_POS;
            end else if (fl.pos_ok) begin
               state_d = TPS_READY;
            end
         end
         default: begin
            state_d = TPS_OFF;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (halt) begin
         state_q <= TPS_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Soft-start phase timer; a restart through TPS_OFF or TPS_REF begins again at phase one, a main fault return to TPS_MAIN keeps the full ceiling.
   logic [$clog2(PHASE_CYC+1)-1:0] phase_cnt_q;
   logic [1:0]                     phase_q;

   always_ff @(posedge clock) begin
      if (halt || state_q == TPS_OFF || state_q == TPS_REF) begin
         phase_cnt_q <= '0;
         phase_q     <= CEIL_QUARTER;
      end else if (fl.main_ok) begin
         phase_q     <= CEIL_FULL;
      end else if (phase_q != CEIL_FULL) begin
         if (phase_cnt_q == ($bits(phase_cnt_q))'(PHASE_CYC - 1)) begin
            phase_cnt_q <= '0;
            phase_q     <= phase_q + 2'h1;
         end else begin
            phase_cnt_q <= phase_cnt_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pump clock at half the oscillator; the oscillator tick is a divided enable.
   logic [$clog2(OSC_DIV)-1:0] osc_cnt_q;
   logic                       osc_tick;

   always_ff @(posedge clock) begin
      if (halt || osc_cnt_q == ($bits(osc_cnt_q))'(OSC_DIV - 1)) begin
         osc_cnt_q <= '0;
      end else begin
         osc_cnt_q <= osc_cnt_q + 1'b1;
      end
   end
   assign osc_tick = (osc_cnt_q == ($bits(osc_cnt_q))'(OSC_DIV - 1));

   always_ff @(posedge clock) begin
      if (halt) begin
         pump_clock <= 1'b0;
      end else if (osc_tick) begin
         pump_clock <= ~pump_clock;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pump ramp references rise linearly over the ramp time, independent of load.
   localparam int unsigned RAMP_STEP = RAMP_CYC / (2 ** RAMP_W);
   logic [$clog2(RAMP_STEP+1)-1:0] ramp_cnt_q;
   logic                           ramp_tick;
   logic                           neg_on;
   logic                           pos_on;

   assign neg_on = (state_q == TPS_NEG) || (state_q == TPS_POS) || (state_q == TPS_READY);
   assign pos_on = (state_q == TPS_POS) || (state_q == TPS_READY);

   always_ff @(posedge clock) begin
      if (halt || ramp_tick) begin
         ramp_cnt_q <= '0;
      end else begin
         ramp_cnt_q <= ramp_cnt_q + 1'b1;
      end
   end
   assign ramp_tick = (ramp_cnt_q == ($bits(ramp_cnt_q))'(RAMP_STEP - 1));

   always_ff @(posedge clock) begin
      if (halt || !neg_on) begin
         neg_ramp_level <= '0;
      end else if (ramp_tick && neg_ramp_level != {RAMP_W{1'b1}}) begin
         neg_ramp_level <= neg_ramp_level + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (halt || !pos_on) begin
         pos_ramp_level <= '0;
      end else if (ramp_tick && pos_ramp_level != {RAMP_W{1'b1}}) begin
         pos_ramp_level <= pos_ramp_level + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // All enables are registered so every output comes straight from a flip-flop.
   always_ff @(posedge clock) begin
      if (halt) begin
         ref_enable             <= 1'b0;
         ref_discharge          <= 1'b1;
         main_enable            <= 1'b0;
         neg_pump_enable        <= 1'b0;
         pos_pump_enable        <= 1'b0;
         switch_current_ceiling <= CEIL_QUARTER;
         ready_n_oe_n           <= 1'b1;
      end else begin
         ref_enable             <= 1'b1;
         ref_discharge          <= 1'b0;
         main_enable            <= (state_q != TPS_OFF) && (state_q != TPS_REF);
         neg_pump_enable        <= neg_on;
         pos_pump_enable        <= pos_on;
         switch_current_ceiling <= phase_q;
         ready_n_oe_n           <= !(state_d == TPS_READY);
      end
   end

   // Open drain: the pin only ever drives low.
   always_ff @(posedge clock) begin
      ready_n_out <= 1'b0;
   end

   // Sticky record of any fault flag while running; cleared by shutdown.
   always_ff @(posedge clock) begin
      if (halt) begin
         fault_seen <= 1'b0;
      end else if (fl.ref_flt || fl.main_flt || fl.neg_flt || fl.pos_flt) begin
         fault_seen <= 1'b1;
      end
   end
endmodule

// ### test/tps_seq_assertions.sv
// Port-level checks for the power sequencer.
// Assumes a bind to tps_seq, one clock and rst as reset.
`timescale 1ns/100ps
module tps_seq_assertions
   import tps_pkg::*;
#(
   parameter int unsigned PHASE_CYC = 20
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       converter_off_n,
   input wire logic       ref_fault,
   input wire logic       main_fault,
   input wire logic       neg_fault,
   input wire logic       pos_fault,
   input wire logic       ref_enable,
   input wire logic       ref_discharge,
   input wire logic       main_enable,
   input wire logic [1:0] switch_current_ceiling,
   input wire logic       neg_pump_enable,
   input wire logic       pos_pump_enable,
   input wire logic       pump_clock,
   input wire logic       ready_n_out,
   input wire logic       ready_n_oe_n
);
   localparam int FULL_LIM = 3 * PHASE_CYC + 8;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // Four low samples cover the shutdown synchroniser and the state update.
   property p_off_quiet; (!converter_off_n) [*4]
      |-> !(ref_enable || main_enable || neg_pump_enable || pos_pump_enable); endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("rails on in shutdown");
   property p_ref_ground; !converter_off_n [*4] |-> ref_discharge; endproperty
   a_ref_ground: assert property (p_ref_ground) else $error("reference not grounded");
   property p_off_init; !converter_off_n [*4] |-> ready_n_oe_n && switch_current_ceiling == CEIL_QUARTER; endproperty
   a_off_init: assert property (p_off_init) else $error("shutdown left state");
   property p_main_start; $rose(main_enable) |-> ref_enable && switch_current_ceiling == CEIL_QUARTER; endproperty
   a_main_start: assert property (p_main_start) else $error("boost start wrong");
   property p_step; main_enable && $changed(switch_current_ceiling) && switch_current_ceiling != CEIL_FULL
      |-> switch_current_ceiling == $past(switch_current_ceiling) + 2'h1; endproperty
   a_step: assert property (p_step) else $error("ceiling skipped a step");
   property p_full; $rose(main_enable) |-> ##[1:FULL_LIM] switch_current_ceiling == CEIL_FULL; endproperty
   a_full: assert property (p_full) else $error("full ceiling late");
   property p_neg; $rose(neg_pump_enable) |-> main_enable && switch_current_ceiling == CEIL_FULL; endproperty
   a_neg: assert property (p_neg) else $error("negative pump early");
   property p_pos; $rose(pos_pump_enable) |-> neg_pump_enable; endproperty
   a_pos: assert property (p_pos) else $error("positive pump early");
   property p_rdy; $fell(ready_n_oe_n) |-> pos_pump_enable && ready_n_out == 1'b0; endproperty
   a_rdy: assert property (p_rdy) else $error("ready early");
   property p_rdy_drop; !ready_n_oe_n && (ref_fault || main_fault || neg_fault || pos_fault)
      |-> ##[1:6] ready_n_oe_n; endproperty
   a_rdy_drop: assert property (p_rdy_drop) else $error("ready held on fault");
   property p_later; !ready_n_oe_n && neg_fault |-> ##[1:6] (!pos_pump_enable && main_enable); endproperty
   a_later: assert property (p_later) else $error("fault ordering wrong");
   property p_pump; $changed(pump_clock) |=> ($stable(pump_clock) || !converter_off_n) [*8]; endproperty
   a_pump: assert property (p_pump) else $error("pump clock too fast");
endmodule

// ### test/tps_rail_model.sv
// Rail model: each feedback flag rises some cycles after its enable.
// Assumes enables from tps_seq; main_slow delays boost regulation.
`timescale 1ns/100ps
module tps_rail_model (
   input  wire logic [3:0] en,
   input  wire logic [3:0] sag,
   input  wire logic       clock,
   input  wire logic       main_slow,
   output logic      [3:0] good
);
   logic [7:0] cnt_q [4];
   always_ff @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         cnt_q[i] <= !en[i] ? 8'h00 : (cnt_q[i] == 8'hFF) ? cnt_q[i] : cnt_q[i] + 8'h01;
      end
   end
   // A dropped enable clears the rail at the next clock edge, as a collapsed output would.
   // A rail held in fault also reads below its power-up level, as a sagging output must.
   assign good[0] = !sag[0] && (cnt_q[0] > 8'h04);
   assign good[1] = !sag[1] && (cnt_q[1] > (main_slow ? 8'h64 : 8'h06));
   assign good[2] = !sag[2] && (cnt_q[2] > 8'h06);
   assign good[3] = !sag[3] && (cnt_q[3] > 8'h06);
endmodule

// ### test/tb_triple_rail_power_sequencer.sv
// Self-checking bench for tps_seq with the rail model.
// Assumes a 20 MHz clock and shortened phase and ramp counts.
`timescale 1ns/100ps
module tb_triple_rail_power_sequencer;
   import tps_pkg::*;
   localparam int PH = 20;
   logic              clock, rst, converter_off_n, main_slow;
   logic        [3:0] flt, good, en;
   logic              ref_discharge, pump_clock, ready_n_out, ready_n_oe_n, fault_seen;
   logic        [1:0] switch_current_ceiling;
   logic [RAMP_W-1:0] neg_ramp_level, pos_ramp_level;
   int                n_errors, tests_run, n;
   tps_seq #(.PHASE_CYC(PH), .RAMP_CYC(512)) dut_u (.clock(clock), .rst(rst), .converter_off_n(converter_off_n),
      .ref_good(good[0]), .main_feedback(good[1]), .neg_pump_feedback(good[2]), .pos_pump_feedback(good[3]),
      .ref_fault(flt[0]), .main_fault(flt[1]), .neg_fault(flt[2]), .pos_fault(flt[3]),
      .ref_enable(en[0]), .ref_discharge(ref_discharge), .main_enable(en[1]),
      .switch_current_ceiling(switch_current_ceiling), .neg_pump_enable(en[2]), .pos_pump_enable(en[3]),
      .pump_clock(pump_clock), .neg_ramp_level(neg_ramp_level), .pos_ramp_level(pos_ramp_level),
      .ready_n_out(ready_n_out), .ready_n_oe_n(ready_n_oe_n), .fault_seen(fault_seen));
   tps_rail_model partner_u (.en(en), .sag(flt), .clock(clock), .main_slow(main_slow), .good(good));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clock);
   endtask
   task automatic wait_ready();
      n = 0;
      while (ready_n_oe_n !== 1'b0 && n < 3000) begin
         tick(1);
         n++;
      end
      check("ready_n_oe_n", 8'h00, {7'h00, ready_n_oe_n});
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      converter_off_n = 1'b1;
      main_slow = 1'b0;
      flt = 4'h0;
      n_errors = 0;
      tests_run = 0;
      tick(8);
      check("enables", 8'h00, {4'h0, en});
      check("ref_discharge", 8'h01, {7'h00, ref_discharge});
      rst = 1'b0;
      wait_ready();
      check("ref_discharge", 8'h00, {7'h00, ref_discharge});
      check("enables", 8'h0F, {4'h0, en});
      check("ceiling", {6'h00, CEIL_FULL}, {6'h00, switch_current_ceiling});
      check("ready_n_out", 8'h00, {7'h00, ready_n_out});
      @(posedge pump_clock);
      n = 0;
      tick(1);
      while (pump_clock === 1'b1 && n < 100) begin
         n++;
         tick(1);
      end
      check("pump_half", 8'h14, 8'(n));
      $display("test power_up done");
      for (int i = 0; i < 4; i++) begin
         flt[i] = 1'b1;
         tick(6);
         check("ready_n_oe_n", 8'h01, {7'h00, ready_n_oe_n});
         check("enables", 8'((1 << (i + 1)) - 1), {4'h0, en});
         check("fault_seen", 8'h01, {7'h00, fault_seen});
         flt[i] = 1'b0;
         wait_ready();
      end
      $display("test faults done");
      converter_off_n = 1'b0;
      tick(6);
      check("enables", 8'h00, {4'h0, en});
      check("ref_discharge", 8'h01, {7'h00, ref_discharge});
      check("fault_seen", 8'h00, {7'h00, fault_seen});
      main_slow = 1'b1;
      converter_off_n = 1'b1;
      n = 0;
      while (en[1] !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      check("main_enable", 8'h01, {7'h00, en[1]});
      check("ceiling", {6'h00, CEIL_QUARTER}, {6'h00, switch_current_ceiling});
      check("ref_enable", 8'h01, {7'h00, en[0]});
      for (int k = 1; k < 4; k++) begin
         n = 0;
         while (switch_current_ceiling !== 2'(k) && n < 100) begin
            tick(1);
            n++;
         end
         check("phase_len_ok", 8'h01, {7'h00, n >= PH - 2 && n <= PH + 2});
         check("neg_enable", 8'h00, {7'h00, en[2]});
      end
      wait_ready();
      check("pos_ramp_start", 8'h01, {7'h00, pos_ramp_level < 8'h40});
      $display("test restart done");
      tick(600);
      check("neg_ramp", 8'hFF, neg_ramp_level);
      check("pos_ramp", 8'hFF, pos_ramp_level);
      $display("test ramp done");
      final_report();
   end
   // The full run takes under two thousand cycles.
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      final_report();
   end
endmodule
bind tps_seq tps_seq_assertions #(.PHASE_CYC(PHASE_CYC)) chk_u (.clock(clock), .rst(rst),
   .converter_off_n(converter_off_n), .ref_fault(ref_fault), .main_fault(main_fault), .neg_fault(neg_fault),
   .pos_fault(pos_fault), .ref_enable(ref_enable), .ref_discharge(ref_discharge), .main_enable(main_enable),
   .switch_current_ceiling(switch_current_ceiling), .neg_pump_enable(neg_pump_enable),
   .pos_pump_enable(pos_pump_enable), .pump_clock(pump_clock), .ready_n_out(ready_n_out),
   .ready_n_oe_n(ready_n_oe_n));
